// ==== verilog/acie_core.sv ====
// Function
// - file address field is seven bits, locations 0x00 to 0x7F
// - bit field selects one of bits 0 to 7 of the file byte
// - literal field is eight or eleven bits depending on instruction
// - don't-care opcode bits are ignored; tools should emit them as zero
// - destination bit 0 writes accumulator, 1 writes the addressed file register
// - flags set by the instruction override data written to status
// - reading program counter low byte leaves the high holding latch unchanged
// - low byte write loads result and copies holding latch into high byte
// - program counter high byte has no file address; only via latch
// - bit set and clear read whole byte, change one bit, write back
// - hardware status bits change only in phase one
// - instruction cycle is exactly four phases of one clock each
// - decode, read, process, write in phases one to four
// - add literal adds 8-bit literal into accumulator, updates C DC Z
// - add accumulator to file writes sum to chosen destination, updates C DC Z
// - program counter change or true skip costs a second, empty cycle
// - port register used as source takes pin values, not the latch
//
// Register access over APB and the placing of the registers were left to the implementer.
module acie_core
  import acie_pkg::*;
(
  input wire logic i_clk, // 50 MHz core clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_ce, // clock enable, freezes all state when low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [11:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error on unmapped address
  output logic [12:0] o_pm_addr, // program memory address
  input wire logic [13:0] i_pm_data, // program memory word
  output logic [6:0] o_file_addr, // file register address
  output logic o_file_re, // file read strobe, phase two
  output logic o_file_we, // file write strobe, phase four
  output logic [7:0] o_file_wdata, // file write data
  input wire logic [7:0] i_file_rdata, // file read data
  input wire logic [7:0] i_port_pins, // port pin levels
  input wire logic i_hw_event, // hardware event, sets event flag
  output logic [1:0] o_phase // current phase, 0 = first
);
  acie_phase_t phase_q;
  acie_phase_t phase_nx;
  logic run_q;
  logic [13:0] ir_q;
  logic [12:0] pc_q;
  logic [12:0] cur_pc_q;
  logic [7:0] w_q;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] pc_high_holding_latch_q;
  logic [7:0] event_q;
  logic pend_q;
  logic [7:0] opnd_q;
  logic [7:0] res_q;
  logic c_q;
  logic dc_q;
  logic z_q;
  logic [6:0] file_addr_q;
  logic file_re_q;
  logic file_we_q;
  logic [7:0] file_wdata_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // decode fields
  wire [6:0] faddr = ir_q[6:0];
  wire dsel = ir_q[7];
  wire [2:0] bsel = ir_q[9:7];
  wire [7:0] lit8 = ir_q[7:0];
  wire [10:0] lit11 = ir_q[10:0];

  // opcode match, x bits left out of each compare
  wire is_add_acc_to_file = (ir_q[13:8] == OPC_ADD_ACC_TO_FILE);
  wire is_add_literal_to_acc = (ir_q[13:9] == OPC_ADD_LITERAL_TO_ACC);
  wire is_clear_file_register = (ir_q[13:8] == OPC_CLR) && dsel;
  wire is_clrw = (ir_q[13:8] == OPC_CLR) && !dsel;
  wire is_movf = (ir_q[13:8] == OPC_MOVF);
  wire is_movwf = (ir_q[13:7] == OPC_MOVWF);
  wire is_movlw = (ir_q[13:10] == OPC_MOVLW);
  wire is_bcf = (ir_q[13:10] == OPC_BCF);
  wire is_bsf = (ir_q[13:10] == OPC_BSF);
  wire is_btfsc = (ir_q[13:10] == OPC_BTFSC);
  wire is_btfss = (ir_q[13:10] == OPC_BTFSS);
  wire is_goto = (ir_q[13:11] == OPC_GOTO);
  // unlisted and reserved encodings fall through as no-operation

  wire is_int = (faddr == FA_PCL) || (faddr == FA_STATUS) || (faddr == FA_PC_HIGH_HOLDING_LATCH)
    || (faddr == FA_EVENT);
  wire needs_read = is_add_acc_to_file || is_movf || is_clear_file_register || is_bcf || is_bsf || is_btfsc
    || is_btfss;
  wire dest_file = ((is_add_acc_to_file || is_movf) && dsel) || is_clear_file_register || is_movwf || is_bcf
    || is_bsf;
  wire dest_w = ((is_add_acc_to_file || is_movf) && !dsel) || is_clrw || is_add_literal_to_acc
    || is_movlw;
  wire fl_add = is_add_acc_to_file || is_add_literal_to_acc;
  wire fl_z = fl_add || is_clear_file_register || is_clrw || is_movf;
  wire pcl_wr = dest_file && (faddr == FA_PCL);
  wire opnd_bit = opnd_q[bsel];
  wire skip = (is_btfsc && !opnd_bit) || (is_btfss && opnd_bit);
  wire redirect = pcl_wr || is_goto;

  // freeze only between cycles so a stop never splits an instruction
  wire adv = i_ce && (run_q || (phase_q != PH_Q1));
  wire at_q1 = adv && (phase_q == PH_Q1);
  wire at_q2 = adv && (phase_q == PH_Q2);
  wire at_q3 = adv && (phase_q == PH_Q3);
  wire at_q4 = adv && (phase_q == PH_Q4);

  // operand source; port reads the pins so self-updates see real levels
  wire [7:0] src = (faddr == FA_PCL) ? cur_pc_q[7:0]
    : (faddr == FA_STATUS) ? status_q
    : (faddr == FA_PC_HIGH_HOLDING_LATCH) ? pc_high_holding_latch_q
    : (faddr == FA_EVENT) ? event_q
    : (faddr == FA_PORT) ? i_port_pins
    : i_file_rdata;

  wire acie_aluop_t alu_op = is_add_acc_to_file ? ALU_ADD : is_add_literal_to_acc ? ALU_ADDL
    : (is_clear_file_register || is_clrw) ? ALU_CLR : is_movwf ? ALU_PASS_W : is_movlw ? ALU_MOVL
    : is_bsf ? ALU_BSET : is_bcf ? ALU_BCLR : ALU_PASS_F;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire alu_z;

  acie_alu u_alu (
    .i_op(alu_op),
    .i_acc(w_q),
    .i_opnd(opnd_q),
    .i_lit(lit8),
    .i_bit(bsel),
    .o_res(alu_res),
    .o_carry(alu_c),
    .o_dcarry(alu_dc),
    .o_zero(alu_z)
  );

  // low byte write takes the upper bits from the latch, never a carry
  wire [12:0] pc_nx = pcl_wr ? {pc_high_holding_latch_q[PCH_MSB:0], res_q}
    : is_goto ? {pc_high_holding_latch_q[PCH_MSB:PAGE_LSB], lit11}
    : 13'(pc_q + 13'h0001);
  wire [13:0] ir_nx = (redirect || skip) ? INSN_NOP : i_pm_data;

  always_comb
  begin
    case (phase_q)
      PH_Q1: phase_nx = PH_Q2;
      PH_Q2: phase_nx = PH_Q3;
      PH_Q3: phase_nx = PH_Q4;
      default: phase_nx = PH_Q1;
    endcase
  end

  // status: flags computed by the instruction win over written data
  always_comb
  begin
    status_d = status_q;
    if (dest_file && (faddr == FA_STATUS))
      status_d = res_q;
    if (fl_add)
    begin
      status_d[STAT_C] = c_q;
      status_d[STAT_DC] = dc_q;
    end
    if (fl_z)
      status_d[STAT_Z] = z_q;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      phase_q <= PH_Q1;
    else if (adv)
      phase_q <= phase_nx;
  end

  // phase one decode, two read, three process, four write
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      file_addr_q <= 7'h00;
      file_re_q <= 1'b0;
      file_we_q <= 1'b0;
      file_wdata_q <= 8'h00;
      opnd_q <= 8'h00;
    end
    else if (at_q1)
    begin
      file_addr_q <= faddr;
      file_re_q <= needs_read && !is_int;
    end
    else if (at_q2)
    begin
      opnd_q <= src;
      file_re_q <= 1'b0;
    end
    else if (at_q3)
    begin
      file_we_q <= dest_file && !is_int;
      file_wdata_q <= alu_res;
    end
    else if (at_q4)
      file_we_q <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      res_q <= 8'h00;
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
    end
    else if (at_q3)
    begin
      res_q <= alu_res;
      c_q <= alu_c;
      dc_q <= alu_dc;
      z_q <= alu_z;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      w_q <= ACC_RST;
      status_q <= STATUS_RST;
      pc_high_holding_latch_q <= PC_HIGH_HOLDING_LATCH_RST;
    end
    else if (at_q4)
    begin
      if (dest_w)
        w_q <= res_q;
      status_q <= status_d;
      if (dest_file && (faddr == FA_PC_HIGH_HOLDING_LATCH))
        pc_high_holding_latch_q <= res_q;
    end
  end

  // fetch at the close of each cycle; a redirect discards the prefetch
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ir_q <= INSN_NOP;
      pc_q <= PC_RST;
      cur_pc_q <= PC_RST;
    end
    else if (at_q4)
    begin
      ir_q <= ir_nx;
      pc_q <= pc_nx;
      cur_pc_q <= redirect ? pc_nx : pc_q;
    end
  end

  // device events land in phase one only, never across a read-modify-write
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pend_q <= 1'b0;
    else if (i_ce)
      pend_q <= at_q1 ? 1'b0 : (pend_q || i_hw_event);
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      event_q <= EVENT_RST;
    else if (at_q1 && (pend_q || i_hw_event))
      event_q[EVT_BIT] <= 1'b1;
    else if (at_q4 && dest_file && (faddr == FA_EVENT))
      event_q <= res_q;
  end

  // apb slave: one wait-free access phase after setup
  wire setup = i_psel && !i_penable;
  wire wr_fire = i_psel && i_penable && pready_q && i_pwrite;
  wire addr_ok = (i_paddr == REG_CTRL) || (i_paddr == REG_ACC) || (i_paddr == REG_PC)
    || (i_paddr == REG_FLAGS);
  wire [31:0] rd_mux = (i_paddr == REG_CTRL) ? 32'(run_q)
    : (i_paddr == REG_ACC) ? 32'(w_q)
    : (i_paddr == REG_PC) ? 32'(pc_q)
    : (i_paddr == REG_FLAGS) ? {16'h0000, pc_high_holding_latch_q, status_q}
    : 32'h00000000;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else if (i_ce)
    begin
      pready_q <= setup;
      pslverr_q <= setup && !addr_ok;
      prdata_q <= setup ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      run_q <= CTRL_RUN_RST;
    else if (i_ce && wr_fire && (i_paddr == REG_CTRL))
      run_q <= i_pwdata[CTRL_RUN_BIT];
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_pm_addr = pc_q;
  assign o_file_addr = file_addr_q;
  assign o_file_re = file_re_q;
  assign o_file_we = file_we_q;
  assign o_file_wdata = file_wdata_q;
  assign o_phase = phase_q;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_cycle;
    at_q1 ##1 adv ##1 adv ##1 adv;
  endsequence

  sequence s_clr_status;
    at_q4 && is_clear_file_register && (faddr == FA_STATUS);
  endsequence

  phase_wrap_a: assert property (s_cycle |=> phase_q == PH_Q1)
    else $error("instruction cycle is not four phases");
  file_wr_q4_a: assert property (o_file_we |-> phase_q == PH_Q4)
    else $error("file write outside phase four");
  file_rd_q2_a: assert property (o_file_re |-> phase_q == PH_Q2)
    else $error("file read outside phase two");
  clr_status_a: assert property (s_clr_status |=> status_q == (8'h01 << STAT_Z))
    else $error("cleared status does not hold only zero flag");
  pcl_load_a: assert property (at_q4 && pcl_wr
    |=> pc_q == {$past(pc_high_holding_latch_q[PCH_MSB:0]), $past(res_q)})
    else $error("low byte write did not load high byte from latch");
  latch_keep_a: assert property (at_q4 && (faddr == FA_PCL) && dest_w
    |=> pc_high_holding_latch_q == $past(pc_high_holding_latch_q))
    else $error("reading low byte changed holding latch");
  redirect_nop_a: assert property (at_q4 && (redirect || skip)
    |=> ir_q == INSN_NOP ##1 !o_file_re [*3])
    else $error("second cycle after redirect is not empty");
  add_literal_to_acc_sum_a: assert property (at_q4 && is_add_literal_to_acc
    |=> w_q == 8'($past(w_q) + $past(lit8)))
    else $error("add literal result wrong");
  event_q1_a: assert property ($rose(event_q[EVT_BIT])
    |-> ($past(phase_q) == PH_Q1) || $past(at_q4 && dest_file && (faddr == FA_EVENT)))
    else $error("event flag set outside phase one");
  bit_set_a: assert property (at_q3 && is_bsf
    |=> o_file_wdata == ($past(opnd_q) | (8'h01 << $past(bsel))))
    else $error("bit set changed more than the selected bit");
  dest_w_a: assert property (at_q3 && is_add_acc_to_file && !dsel |=> !o_file_we)
    else $error("accumulator destination wrote the file");
endmodule : acie_core

// ==== verilog/acie_pkg.sv ====
package acie_pkg;
  // clocking: each instruction cycle is four oscillator periods
  localparam int unsigned CLK_FREQ_HZ = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
  localparam int unsigned PHASES_PER_CYCLE = 4;

  // apb register byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ACC = 12'h004;
  localparam logic [11:0] REG_PC = 12'h008;
  localparam logic [11:0] REG_FLAGS = 12'h00C;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RST = 1'b0;

  // file register map; all but the port are held inside the core, port writes go to the file bus
  localparam logic [6:0] FA_PCL = 7'h02;
  localparam logic [6:0] FA_STATUS = 7'h03;
  localparam logic [6:0] FA_PORT = 7'h06;
  localparam logic [6:0] FA_PC_HIGH_HOLDING_LATCH = 7'h0A;
  localparam logic [6:0] FA_EVENT = 7'h0B;

  // status and event bit positions
  localparam int unsigned STAT_C = 0;
  localparam int unsigned STAT_DC = 1;
  localparam int unsigned STAT_Z = 2;
  localparam int unsigned STAT_OV = 6;
  localparam int unsigned EVT_BIT = 0;
  localparam int unsigned PCH_MSB = 4;
  localparam int unsigned PAGE_LSB = 3;

  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] PC_HIGH_HOLDING_LATCH_RST = 8'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] EVENT_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [13:0] INSN_NOP = 14'h0000;

  // opcode patterns, don't-care bits excluded from each compare
  localparam logic [5:0] OPC_ADD_ACC_TO_FILE = 6'h07;
  localparam logic [5:0] OPC_CLR = 6'h01;
  localparam logic [5:0] OPC_MOVF = 6'h08;
  localparam logic [6:0] OPC_MOVWF = 7'h01;
  localparam logic [4:0] OPC_ADD_LITERAL_TO_ACC = 5'h1F;
  localparam logic [3:0] OPC_MOVLW = 4'hC;
  localparam logic [3:0] OPC_BCF = 4'h4;
  localparam logic [3:0] OPC_BSF = 4'h5;
  localparam logic [3:0] OPC_BTFSC = 4'h6;
  localparam logic [3:0] OPC_BTFSS = 4'h7;
  localparam logic [2:0] OPC_GOTO = 3'h5;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} acie_phase_t;
  typedef enum logic [2:0] {
    ALU_ADD, ALU_ADDL, ALU_PASS_W, ALU_PASS_F, ALU_MOVL, ALU_CLR, ALU_BSET, ALU_BCLR
  } acie_aluop_t;
endpackage : acie_pkg

// ==== verilog/acie_alu.sv ====
module acie_alu
  import acie_pkg::*;
(
  input wire acie_aluop_t i_op, // operation
  input wire logic [7:0] i_acc, // accumulator
  input wire logic [7:0] i_opnd, // file operand
  input wire logic [7:0] i_lit, // 8-bit literal
  input wire logic [2:0] i_bit, // bit select
  output logic [7:0] o_res, // result byte
  output logic o_carry, // carry out of bit 7
  output logic o_dcarry, // carry out of bit 3
  output logic o_zero // result is zero
);
  logic [7:0] bit_hit;
  logic [7:0] add_b;
  logic [8:0] sum;
  logic [4:0] nib;

  for (genvar gi = 0; gi < 8; gi++)
  begin : g_bit
    assign bit_hit[gi] = (i_bit == 3'(gi));
  end

  assign add_b = (i_op == ALU_ADDL) ? i_lit : i_opnd;
  assign sum = {1'b0, i_acc} + {1'b0, add_b};
  assign nib = {1'b0, i_acc[3:0]} + {1'b0, add_b[3:0]};
  assign o_carry = sum[8];
  assign o_dcarry = nib[4];
  assign o_zero = (o_res == 8'h00);

  always_comb
  begin
    case (i_op)
      ALU_ADD: o_res = sum[7:0];
      ALU_ADDL: o_res = sum[7:0];
      ALU_PASS_W: o_res = i_acc;
      ALU_MOVL: o_res = i_lit;
      ALU_CLR: o_res = 8'h00;
      ALU_BSET: o_res = i_opnd | bit_hit;
      ALU_BCLR: o_res = i_opnd & ~bit_hit;
      default: o_res = i_opnd;
    endcase
  end
endmodule : acie_alu

// ==== test/acie_mem_model.sv ====
module acie_mem_model
(
  input wire logic i_clk, // core clock
  input wire logic [12:0] i_pm_addr, // fetch address
  output logic [13:0] o_pm_data, // fetched word
  input wire logic [6:0] i_file_addr, // file address
  input wire logic i_file_re, // read strobe
  input wire logic i_file_we, // write strobe
  input wire logic [7:0] i_file_wdata, // write data
  output logic [7:0] o_file_rdata // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] prog [0:31];
  logic [7:0] ram [0:127];
  logic [7:0] last_q = 8'h00;
  // only a small program space; the bench keeps code inside it
  assign o_pm_data = prog[i_pm_addr[4:0]];
  // released bus shows the inverse, so a late sample cannot pass by luck
  assign o_file_rdata = i_file_re ? ram[i_file_addr] : ~last_q;
  always @(posedge i_clk)
  begin
    if (i_file_re)
      last_q <= ram[i_file_addr];
    if (i_file_we)
      ram[i_file_addr] <= i_file_wdata;
  end
endmodule : acie_mem_model

// ==== test/accumulator_core_insn_exec_tb_top.sv ====
module accumulator_core_insn_exec_tb_top
  import acie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, re, we, err, hw_event;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] pm_addr;
  logic [13:0] pm_data;
  logic [6:0] faddr;
  logic [7:0] wdata, rdata;
  logic [1:0] phase;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  acie_core dut (.i_clk(clk), .i_rstn(rstn), .i_ce(1'b1), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_pm_addr(pm_addr), .i_pm_data(pm_data),
    .o_file_addr(faddr), .o_file_re(re), .o_file_we(we), .o_file_wdata(wdata),
    .i_file_rdata(rdata), .i_port_pins(8'h5A), .i_hw_event(hw_event), .o_phase(phase));
  acie_mem_model mdl (.i_clk(clk), .i_pm_addr(pm_addr), .o_pm_data(pm_data),
    .i_file_addr(faddr), .i_file_re(re), .i_file_we(we), .i_file_wdata(wdata),
    .o_file_rdata(rdata));
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end
  task print_verdict;
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no answer time is assumed; only the bench timeout ends this wait
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task t_unmapped;
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, REG_ACC, 32'h0);
    chk({31'h0, err}, 32'h0);
    chk(rd, 32'h0);
  endtask : t_unmapped
  task t_program;
    // about seventeen instruction cycles until the program parks in its loop
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (100) @(posedge clk);
    apb(1'b0, REG_ACC, 32'h0);
    chk(rd, 32'h12);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rd, 32'h02);
    // parked loop alternates between its own address and the next one
    apb(1'b0, REG_PC, 32'h0);
    chk(rd & 32'hFFFFFFFE, 32'h14);
    chk({24'h0, mdl.ram[7'h20]}, 32'h45);
    chk({24'h0, mdl.ram[7'h21]}, 32'h8A);
    chk({24'h0, mdl.ram[7'h06]}, 32'h5A);
  endtask : t_program
  task t_phases;
    logic [1:0] prev;
    @(posedge clk);
    prev = phase;
    repeat (8)
    begin
      @(posedge clk);
      chk({30'h0, phase}, {30'h0, prev + 2'h1});
      prev = phase;
    end
  endtask : t_phases
  task t_event;
    chk({31'h0, dut.event_q[EVT_BIT]}, 32'h0);
    hw_event <= 1'b1;
    @(posedge clk);
    hw_event <= 1'b0;
    // more than one instruction cycle, so a phase one edge has surely passed
    repeat (6) @(posedge clk);
    chk({31'h0, dut.event_q[EVT_BIT]}, 32'h1);
  endtask : t_event
  task t_stop;
    logic [31:0] pc_seen;
    apb(1'b1, REG_CTRL, 32'h0);
    repeat (8) @(posedge clk);
    apb(1'b0, REG_PC, 32'h0);
    pc_seen = rd;
    chk(pc_seen & 32'hFFFFFFFE, 32'h14);
    repeat (8) @(posedge clk);
    chk({30'h0, phase}, 32'h0);
    apb(1'b0, REG_PC, 32'h0);
    chk(rd, pc_seen);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
  endtask : t_stop
  // slot 10 must be skipped; slots 12 to 17 lie past the low byte jump
  logic [13:0] code [21] = '{14'h3010, 14'h3F15, 14'h07A0, 14'h0720, 14'h0886,
    14'h17A1, 14'h3E96, 14'h0803, 14'h0183, 14'h1D03, 14'h30EE, 14'h0782,
    14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0802, 14'h0000,
    14'h2814};
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hw_event = 1'b0;
    for (int i = 0; i < 32; i++)
      mdl.prog[i] = (i < 21) ? code[i] : INSN_NOP;
    for (int i = 0; i < 128; i++)
      mdl.ram[i] = 8'hFF;
    mdl.ram[7'h20] = 8'h20;
    mdl.ram[7'h21] = 8'h0A;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_unmapped();
    t_program();
    t_phases();
    t_event();
    t_stop();
    print_verdict();
  end
endmodule : accumulator_core_insn_exec_tb_top
